/* seq_cfg.svh */
// Constants of the event/action sequencer: offsets, codes, reset values.
// Assumes byte addressing on a 32-bit APB bus with 12 address bits.
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH

// Timing
`define CLK_PERIOD_NS     20
`define SCAN_INTERVAL_NS  1000000

// Sizes
`define NUM_SEQ           4
`define NUM_STEPS         20
`define NUM_CMP           4
`define NUM_RULE          4
`define NUM_TIMER         3

// Register offsets and pages
`define OFS_MODE          12'h000
`define OFS_RESTART       12'h004
`define OFS_STATUS        12'h008
`define OFS_LEN           12'h00C
`define OFS_OUTS          12'h01C
`define PAGE_TMR          8'h01
`define PAGE_CMP          8'h02
`define PAGE_RULE         8'h03
`define PAGE_STEP         3'h1

// Reset values and the mode run code
`define LEN_RST           5'h14
`define TMR_RST           16'h0000
`define MODE_ON           1'b1

// Event selector codes
`define EV_FALSE          8'h00
`define EV_TRUE           8'h01
`define EV_STATUS_BASE    8'h02
`define EV_ON_REF         8'h04
`define EV_CMP_BASE       8'h16
`define EV_RULE_BASE      8'h1A
`define EV_TIMEOUT_BASE   8'h1E
`define EV_DIN_BASE       8'h21

// Action selector codes
`define ACT_NONE          8'h01
`define ACT_PRESET_BASE   8'h0A
`define ACT_PRESET_LAST   8'h11
`define ACT_TIMER_BASE    8'h1D

// Comparator operators
`define CMP_LT            2'h0
`define CMP_EQ            2'h1
`define CMP_GT            2'h2

`endif

/* seq_pkg.sv */
// Types shared by the sequencer files.
// Assumes seq_cfg.svh for all numeric constants.
package seq_pkg;

    typedef enum logic {
        SEQ_OFF = 1'b0,
        SEQ_RUN = 1'b1
    } seq_state_e;

    typedef struct packed {
        logic [15:0] aux;
        logic [15:0] analog;
        logic [15:0] current;
        logic [15:0] freq;
    } measure_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } action_s;

    typedef logic [7:0] sel_t;

endpackage

/* value_comparator.sv */
// One comparator: selected quantity against a fixed programmed value.
// Assumes quantity and value on pclk; result refreshed every cycle.
`timescale 1ns/10ps
`include "seq_cfg.svh"

module value_comparator #(
    parameter int W = 16
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] quantity,
    input  wire logic [W-1:0] limit,
    input  wire logic [1:0]   op,
    output logic              result
);

    wire lt = quantity < limit;
    wire eq = quantity == limit;
    wire next_result = (op == `CMP_LT) ? lt :
                       (op == `CMP_EQ) ? eq :
                       (op == `CMP_GT) ? (~lt & ~eq) : ~eq;

    // Runs every clock, whatever the sequencers do
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) result <= 1'b0;
        else          result <= next_result; // R9 R11
    end

    a_cmp_follows: assert property ( // R11
        @(posedge pclk) disable iff (!presetn)
        op == `CMP_GT && quantity > limit |=> result)
        else $error("comparator missed greater-than");

endmodule // value_comparator

/* sequence_timer.sv */
// One sequence timer counting scan intervals after a start action.
// Assumes start and tick are single-cycle pulses on pclk.
`timescale 1ns/10ps
`include "seq_cfg.svh"

module sequence_timer #(
    parameter int W = 16
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         tick,
    input  wire logic         start,
    input  wire logic [W-1:0] duration,
    output logic              expired
);

    logic [W-1:0] count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count   <= '0;
            expired <= 1'b1;
        end else if (start) begin
            count   <= duration;
            expired <= (duration == '0); // R16
        end else if (tick && !expired) begin
            count   <= count - 1'b1;
            expired <= (count <= 1); // R16
        end
    end

    a_start_false: assert property ( // R16
        @(posedge pclk) disable iff (!presetn)
        start && duration != '0 |=> !expired)
        else $error("timer not false after start");

    a_expire_last: assert property ( // R16
        @(posedge pclk) disable iff (!presetn)
        !start && tick && !expired && count == 1 |=> expired)
        else $error("timer late to expire");

endmodule // sequence_timer

/* event_action_sequencer.sv */
// Event/action sequencer: APB registers, comparators, logic rules,
// timers and up to four step sequencers of indexed event/action pairs.
// Assumes pclk at 50 MHz; measurements and status come from logic on
// pclk, digital inputs come from pins.
//
// Notes on behaviour
// R1 - On a true step event, issue that step's action, then take next step
// R2 - Exactly one event, the current step's, is tested at a time
// R3 - False event: no action, no other event, step index unchanged
// R4 - On start only event zero is tested each scan until it is true
// R5 - Sequence length programmable from 1 to 20 pairs
// R6 - After the last programmed pair the step index wraps to zero
// R7 - Up to four independent sequences, linked only through logic rules; here also through the three shared timers
// R8 - Settings switch each sequence on, off and back to its first step
// R9 - Comparators and logic rules update continuously, also as outputs
// R10 - Event source is a status bit, rule or comparator; true fulfils
// R11 - Comparator tests a chosen quantity against a programmed value
// R12 - Logic rule joins up to three operands with AND, OR and NOT
// R13 - Event codes: 1 true, 0 false, 4 on reference, 30 timer 0 out
// R14 - Action codes: 1 none, 10 preset 0, 11 preset 1, 29 start timer 0
// R15 - A sequence runs only while its mode setting holds code 1
// R16 - Timer reads false from its start until its duration elapsed
// R17 - Three timers, each with its own duration
// R18 - Events tested and steps taken only on the periodic scan pulse
// R19 - Off or reset: step index zero and no action until running again
`timescale 1ns/10ps
`include "seq_cfg.svh"

module event_action_sequencer #(
    parameter int NSEQ        = `NUM_SEQ,
    parameter int NSTEPS      = `NUM_STEPS,
    parameter int SCAN_CYCLES = `SCAN_INTERVAL_NS / `CLK_PERIOD_NS
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire seq_pkg::measure_s           meas,
    input  wire logic [7:0]                  drive_status,
    input  wire logic [7:0]                  din,
    output seq_pkg::action_s [NSEQ-1:0]      actions,
    output logic      [2:0]                  preset_sel,
    output logic      [`NUM_CMP-1:0]         cmp_out,
    output logic      [`NUM_RULE-1:0]        rule_out,
    output logic      [`NUM_TIMER-1:0]       timer_out
);
    import seq_pkg::*;

    localparam int TW = $clog2(SCAN_CYCLES);
    localparam int NT = NSEQ * NSTEPS;

    ////////////////////////////////////////////////////////////////////
    // Storage

    logic [NSEQ-1:0]   mode;
    logic [4:0]        seq_len   [NSEQ];
    logic [15:0]       tmr_dur   [`NUM_TIMER];
    logic [31:0]       cmp_cfg   [`NUM_CMP];
    logic [31:0]       rule_cfg  [`NUM_RULE];
    sel_t              evt_tab   [NT];
    sel_t              act_tab   [NT];
    logic [4:0]        step      [NSEQ];
    seq_state_e        state     [NSEQ];
    logic [7:0]        din_meta;
    logic [7:0]        din_sync;
    logic [TW-1:0]     scan_cnt;
    logic              tick;
    logic [31:0]       rd_data;
    logic [63:0]       src;
    logic [`NUM_TIMER-1:0] timer_start;

    ////////////////////////////////////////////////////////////////////
    // APB decode

    wire        access   = psel & penable;
    wire        setup    = psel & ~penable;
    wire        wr_en    = access & pwrite;
    wire [7:0]  page     = paddr[11:4];
    wire [1:0]  sub      = paddr[3:2];
    wire        hit_mode = paddr == `OFS_MODE;
    wire        hit_rst  = paddr == `OFS_RESTART;
    wire        hit_stat = paddr == `OFS_STATUS;
    wire        hit_len  = paddr == `OFS_LEN;
    wire        hit_outs = paddr == `OFS_OUTS;
    wire        hit_tmr  = page == `PAGE_TMR && sub != 2'h3;
    wire        hit_cmp  = page == `PAGE_CMP && paddr[1:0] == 2'h0;
    wire        hit_rule = page == `PAGE_RULE && paddr[1:0] == 2'h0;
    wire [1:0]  st_seq   = paddr[8:7];
    wire [4:0]  st_idx   = paddr[6:2];
    wire        hit_step = paddr[11:9] == `PAGE_STEP &&
                           paddr[1:0] == 2'h0 &&
                           32'(st_seq) < NSEQ && 32'(st_idx) < NSTEPS;
    wire [6:0]  st_ent   = 7'(32'(st_seq) * NSTEPS) + {2'h0, st_idx};
    wire        mapped   = hit_mode | hit_rst | hit_stat | hit_len |
                           hit_outs | hit_tmr | hit_cmp | hit_rule |
                           hit_step;
    wire [NSEQ-1:0] restart = (wr_en && hit_rst) ?
                              pwdata[NSEQ-1:0] : '0; // R8

    // Zero wait states keep the master simple
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit_mode)
            rd_data[NSEQ-1:0] = mode;
        if (hit_stat || hit_len)
            for (int s = 0; s < NSEQ; s++) begin
                rd_data[s*8 +: 5] = hit_len ? seq_len[s] : step[s];
                rd_data[s*8 + 7]  = hit_stat && state[s] == SEQ_RUN;
            end
        if (hit_outs)
            rd_data[10:0] = {timer_out, rule_out, cmp_out};
        if (hit_tmr)
            rd_data[15:0] = tmr_dur[sub];
        if (hit_cmp)
            rd_data = cmp_cfg[sub];
        if (hit_rule)
            rd_data = rule_cfg[sub];
        if (hit_step)
            rd_data[15:0] = {act_tab[st_ent], evt_tab[st_ent]};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)   prdata <= 32'h0000_0000;
        else if (setup) prdata <= rd_data;
    end

    ////////////////////////////////////////////////////////////////////
    // Register writes

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= '0;
            for (int s = 0; s < NSEQ; s++)
                seq_len[s] <= `LEN_RST;
            for (int t = 0; t < `NUM_TIMER; t++)
                tmr_dur[t] <= `TMR_RST;
            for (int k = 0; k < `NUM_CMP; k++) begin
                cmp_cfg[k]  <= 32'h0000_0000;
                rule_cfg[k] <= 32'h0000_0000;
            end
            for (int e = 0; e < NT; e++) begin
                evt_tab[e] <= `EV_FALSE;
                act_tab[e] <= `ACT_NONE;
            end
        end else if (wr_en) begin
            if (hit_mode)
                mode <= pwdata[NSEQ-1:0]; // R8 R15
            if (hit_len)
                for (int s = 0; s < NSEQ; s++)
                    seq_len[s] <= pwdata[s*8 +: 5]; // R5
            if (hit_tmr)
                tmr_dur[sub] <= pwdata[15:0]; // R17
            if (hit_cmp)
                cmp_cfg[sub] <= pwdata;
            if (hit_rule)
                rule_cfg[sub] <= pwdata;
            if (hit_step) begin
                evt_tab[st_ent] <= pwdata[7:0];
                act_tab[st_ent] <= pwdata[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Scan pulse and input sync

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_cnt <= '0;
            tick     <= 1'b0;
            din_meta <= 8'h00;
            din_sync <= 8'h00;
        end else begin
            tick     <= scan_cnt == TW'(SCAN_CYCLES - 1); // R18
            scan_cnt <= (scan_cnt == TW'(SCAN_CYCLES - 1)) ?
                        '0 : scan_cnt + 1'b1;
            din_meta <= din;
            din_sync <= din_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Boolean sources shared by events and rules

    // Bit 0 false, bit 1 true, unlisted codes read false
    assign src = {23'h0, din_sync, timer_out, rule_out, cmp_out,
                  12'h000, drive_status, 2'b10}; // R10 R13

    function automatic logic pick(input sel_t code, input logic [63:0] v);
        pick = (code[7:6] == 2'b00) ? v[code[5:0]] : 1'b0;
    endfunction

    function automatic logic join2(input logic a, input logic b,
                                   input logic [1:0] op);
        case (op)
            2'h0:    join2 = a & b;
            2'h1:    join2 = a | b;
            2'h2:    join2 = a & ~b;
            2'h3:    join2 = a | ~b;
            default: join2 = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Comparators, rules, timers

    wire [63:0] meas_w = meas;

    genvar k;
    generate
        for (k = 0; k < `NUM_CMP; k++) begin : g_cmp
            wire [1:0] qsel = cmp_cfg[k][1:0];
            value_comparator #(.W(16)) u_cmp (
                .pclk     (pclk),
                .presetn  (presetn),
                .quantity (meas_w[{qsel, 4'h0} +: 16]), // R11
                .limit    (cmp_cfg[k][31:16]),
                .op       (cmp_cfg[k][5:4]),
                .result   (cmp_out[k])
            );
        end
        for (k = 0; k < `NUM_RULE; k++) begin : g_rule
            // Registered, so a rule may read any rule without a loop
            wire r12 = join2(pick(rule_cfg[k][7:0], src),
                             pick(rule_cfg[k][15:8], src),
                             rule_cfg[k][25:24]);
            wire r123 = join2(r12, pick(rule_cfg[k][23:16], src),
                              rule_cfg[k][29:28]); // R12
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) rule_out[k] <= 1'b0;
                else          rule_out[k] <= r123; // R9
            end
        end
        for (k = 0; k < `NUM_TIMER; k++) begin : g_tmr
            sequence_timer #(.W(16)) u_tmr (
                .pclk     (pclk),
                .presetn  (presetn),
                .tick     (tick),
                .start    (timer_start[k]),
                .duration (tmr_dur[k]), // R17
                .expired  (timer_out[k])
            );
        end
    endgenerate

    always_comb begin
        timer_start = '0;
        for (int s = 0; s < NSEQ; s++)
            for (int t = 0; t < `NUM_TIMER; t++)
                if (actions[s].valid &&
                    actions[s].code == `ACT_TIMER_BASE + 8'(t))
                    timer_start[t] = 1'b1; // R14 R16
    end

    // Higher sequence wins when two pick a preset together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) preset_sel <= 3'h0;
        else
            for (int s = 0; s < NSEQ; s++)
                if (actions[s].valid &&
                    actions[s].code >= `ACT_PRESET_BASE &&
                    actions[s].code <= `ACT_PRESET_LAST)
                    preset_sel <= 3'(actions[s].code -
                                     `ACT_PRESET_BASE); // R14
    end

    ////////////////////////////////////////////////////////////////////
    // Step sequencers

    genvar s;
    generate
        for (s = 0; s < NSEQ; s++) begin : g_seq // R7
            wire [4:0] len_c  = seq_len[s];
            wire [4:0] eff    = (len_c == 5'h00) ? 5'h01 :
                                (32'(len_c) > NSTEPS) ? 5'(NSTEPS) :
                                len_c; // R5
            wire [6:0] ent    = 7'(s * NSTEPS) + {2'h0, step[s]};
            wire       ev_hit = pick(evt_tab[ent], src); // R2 R10
            wire       last   = {1'b0, step[s]} + 6'h01 >= {1'b0, eff};
            wire       stop   = mode[s] != `MODE_ON || restart[s];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    state[s]   <= SEQ_OFF;
                    step[s]    <= 5'h00;
                    actions[s] <= '0;
                end else begin
                    actions[s].valid <= 1'b0;
                    case (state[s])
                        SEQ_OFF: begin
                            step[s] <= 5'h00; // R19
                            if (!stop) state[s] <= SEQ_RUN; // R15
                        end
                        SEQ_RUN: begin
                            if (stop) begin
                                state[s] <= SEQ_OFF;
                                step[s]  <= 5'h00; // R8 R19
                            end else if (tick && ev_hit) begin // R18
                                actions[s] <= {1'b1, act_tab[ent]}; // R1
                                step[s] <= last ?
                                    5'h00 : step[s] + 5'h01; // R1 R6
                            end
                        end
                        default: state[s] <= SEQ_OFF;
                    endcase
                end
            end

            a_step_hold: assert property ( // R3
                @(posedge pclk) disable iff (!presetn)
                state[s] == SEQ_RUN && !stop && tick && !ev_hit
                |=> $stable(step[s]) && !actions[s].valid)
                else $error("step moved on false event");

            a_step_next: assert property ( // R1
                @(posedge pclk) disable iff (!presetn)
                state[s] == SEQ_RUN && !stop && tick && ev_hit && !last
                |=> step[s] == $past(step[s]) + 5'h01 &&
                    actions[s].valid &&
                    actions[s].code == $past(act_tab[ent]))
                else $error("wrong action or step after true event");

            a_wrap_zero: assert property ( // R6
                @(posedge pclk) disable iff (!presetn)
                state[s] == SEQ_RUN && !stop && tick && ev_hit && last
                |=> step[s] == 5'h00)
                else $error("step did not wrap");

            a_step_range: assert property ( // R5
                @(posedge pclk) disable iff (!presetn)
                32'(step[s]) < NSTEPS)
                else $error("step index out of range");

            a_off_idle: assert property ( // R19
                @(posedge pclk) disable iff (!presetn)
                stop |=> step[s] == 5'h00 && !actions[s].valid [*2])
                else $error("stopped sequence not idle");

            a_run_code: assert property ( // R15
                @(posedge pclk) disable iff (!presetn)
                actions[s].valid |-> $past(mode[s]) == `MODE_ON)
                else $error("action while mode not on");

            a_first_step: assert property ( // R4
                @(posedge pclk) disable iff (!presetn)
                $rose(state[s] == SEQ_RUN) |-> step[s] == 5'h00)
                else $error("sequence started away from step zero");

            a_scan_gate: assert property ( // R18
                @(posedge pclk) disable iff (!presetn)
                actions[s].valid |-> $past(tick) && !tick)
                else $error("action outside scan pulse");
        end
    endgenerate

endmodule // event_action_sequencer

/* drive_model.sv */
// Far-side drive model: output frequency ramps to the selected preset.
// Assumes preset_sel and the current sample change on pclk only.
`timescale 1ns/10ps

module drive_model (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic [2:0]    preset_sel,
    input  wire logic [15:0]   cur,
    output seq_pkg::measure_s  meas,
    output logic [7:0]         drive_status
);
    import seq_pkg::*;
    logic [15:0] freq;
    logic [15:0] target;

    ////////////////////////////////////////////////////////////
    // Slow ramp, so on-reference stays false for a while
    assign target = {5'h00, preset_sel + 3'h1, 8'h00};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            freq <= 16'h0000;
        else if (freq < target)
            freq <= freq + 16'h0001;
        else if (freq > target)
            freq <= freq - 16'h0001;
    end

    assign meas = {16'h0000, 16'h0000, cur, freq};
    assign drive_status = {5'h00, freq == target, 2'h0};
endmodule // drive_model

/* event_action_sequencer_tb.sv */
// Self-checking bench for the event/action sequencer.
// Assumes drive_model on the far side and a 4-cycle scan for speed.
`timescale 1ns/10ps
`include "seq_cfg.svh"

module event_action_sequencer_tb;
    import seq_pkg::*;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic          err, x;
    logic [1:0]    tmr_sh;
    measure_s      meas;
    logic [7:0]    drive_status, din;
    action_s [3:0] actions;
    logic [2:0]    preset_sel, timer_out;
    logic [3:0]    cmp_out, rule_out;
    logic [15:0]   cur, c, l;
    int            err_count, checked, cycles, e;
    int            q[$];
    logic [7:0]    evs [4] = '{8'h21, `EV_ON_REF, `EV_TIMEOUT_BASE, `EV_TRUE};
    logic [7:0]    acts [4] = '{8'h0A, `ACT_TIMER_BASE, 8'h0B, `ACT_NONE};

    event_action_sequencer #(.SCAN_CYCLES(4)) u_event_action_sequencer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .meas(meas),
        .drive_status(drive_status), .din(din), .actions(actions),
        .preset_sel(preset_sel), .cmp_out(cmp_out), .rule_out(rule_out),
        .timer_out(timer_out));
    drive_model u_drive_model (.pclk(pclk), .presetn(presetn),
        .preset_sel(preset_sel), .cur(cur), .meas(meas),
        .drive_status(drive_status));

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Waits until the expected actions are down to left, bounded at 3000 cycles
    task automatic drain(input int left);
        int n;
        n = 0;
        while (q.size() > left && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        check(q.size(), left);
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Sequence 0 action pulses are matched against the queue model; any pulse from sequences 1 to 3 is a mismatch
    always @(posedge pclk) begin
        cycles++;
        if (tmr_sh[1]) check(timer_out[0], 1'b0);
        tmr_sh = {tmr_sh[0], actions[0].valid && actions[0].code == 8'h1D};
        for (int s = 1; s < 4; s++)
            if (actions[s].valid) check(actions[s].code, 32'hFF);
        if (actions[0].valid) begin
            e = (q.size() > 0) ? q.pop_front() : 32'hFF;
            check(actions[0].code, e);
        end
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {din, cur, tmr_sh, err_count, checked, cycles} = '0;
        e = $urandom(32'h46B4);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OFS_MODE, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `OFS_LEN, 32'h0);
        check(rd, 32'h14141414);
        apb(1'b0, 12'h200, 32'h0);
        check(rd, 32'h100);
        apb(1'b0, 12'h100, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        apb(1'b0, `OFS_OUTS, 32'h0);
        check(rd, 32'h700);
        $display("done: reset values");
        apb(1'b1, `OFS_LEN, 32'h14141404);
        apb(1'b1, 12'h010, 32'($urandom_range(3, 2)));
        for (int i = 0; i < 4; i++)
            apb(1'b1, 12'h200 + 12'(i * 4), {16'h0, acts[i], evs[i]});
        apb(1'b1, `OFS_MODE, 32'h3);
        repeat (20) @(posedge pclk);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rd, 32'h8080);
        q.push_back(acts[0]);
        din[0] <= 1'b1;
        drain(0);
        din[0] <= 1'b0;
        apb(1'b1, `OFS_RESTART, 32'h1);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rd, 32'h8080);
        $display("done: hold and restart");
        for (int r = 0; r < 8; r++)
            q.push_back(acts[r % 4]);
        din[0] <= 1'b1;
        drain(1);
        din[0] <= 1'b0;
        drain(0);
        repeat (12) @(posedge pclk);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rd, 32'h8080);
        check(preset_sel, 3'h1);
        apb(1'b1, `OFS_MODE, 32'h0);
        din[0] <= 1'b1;
        repeat (20) @(posedge pclk);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rd, 32'h0);
        $display("done: sequence rounds");
        // Comparators keep running with every sequence off
        apb(1'b1, 12'h030, 32'h1000_2216);
        for (int op = 0; op < 4; op++) begin
            c = 16'($urandom);
            l = (op == 1) ? c : 16'($urandom);
            cur <= c;
            din[1] <= 1'($urandom);
            apb(1'b1, 12'h020, {l, 10'h0, 2'(op), 2'h0, 2'h1});
            repeat (6) @(posedge pclk);
            x = op == 0 ? c < l : op == 1 ? c == l : op == 2 ? c > l : c != l;
            check(cmp_out[0], x);
            check(rule_out[0], x & din[1]);
        end
        $display("done: comparators and rules");
        print_verdict();
    end
endmodule // event_action_sequencer_tb
